// ---- verilog/pipelined_slice_arith.sv ----
`timescale 1ns/100ps
// How it works
// RULE1: pipelined 35x35 multiplier takes a pair and yields a product each cycle.
// RULE2: serial 35x35 variant uses four cycles, changing operands and operation select.
// RULE3: input register stages hold operand parts until the cascade arrives.
// RULE4: low product part is delayed three cycles outside the slices.
// RULE5: one-cycle delays use one flip-flop; longer ones a shift chain plus flip-flop.
// RULE6: complex product: re = ar*br - ai*bi, im = ar*bi + ai*br.
// RULE7: real and imaginary chains alike except final subtract versus add.
// RULE8: complex accumulate keeps four cross products separately for N cycles.
// RULE9: in cycle N+1 results combine, and the source stalls one cycle.
// RULE10: extended accumulate adds one slice so input never stalls.
// RULE11: complex 35x18 splits wide operands into parts, same add/subtract rule.
// RULE12: barrel shifter rotates 18 bits left by n, msbs wrap to lsbs.
// RULE13: first shifter slice holds zeros, operand bits 17:1, then n zeros.
// RULE14: first slice output passes right-shifted 17, leaving the n top bits.
// RULE15: second slice adds operand times 2^n; low 18 bits are the rotation.
// RULE16: two-slice shifter yields a new rotated result every cycle.
// RULE17: single-slice shifter alternates multiply and accumulate; result after accumulate.
// RULE18: 35x35 slices run multiply, shifted-add, accumulate, shifted-add.
// RULE19: operands are signed; low parts are zero-extended by one bit.
// RULE20: the operand source holds off new pairs during each stall cycle.
module pipelined_slice_arith (
	input wire logic i_mclk,
	input wire logic i_rstn,
	input wire logic i_ce,
	input wire slice_arith_pkg::wide_pair_t i_mul_in,
	input wire logic i_mul_vld,
	output slice_arith_pkg::wide_pair_t o_unused_pad,
	output logic signed [69:0] o_mul_p,
	output logic o_mul_vld,
	input wire slice_arith_pkg::wide_pair_t i_ser_in,
	input wire logic i_ser_start,
	output logic o_ser_busy,
	output logic signed [69:0] o_ser_p,
	output logic o_ser_vld,
	input wire slice_arith_pkg::cplx18_t i_c18_a,
	input wire slice_arith_pkg::cplx18_t i_c18_b,
	output slice_arith_pkg::cplx_res_t o_c18_p,
	input wire logic i_multiply_accumulate_vld,
	input wire logic i_multiply_accumulate_last,
	output logic o_multiply_accumulate_stall,
	output slice_arith_pkg::cplx_res_t o_multiply_accumulate_p,
	output logic o_multiply_accumulate_vld,
	output slice_arith_pkg::cplx_res_t o_xmacc_p,
	output logic o_xmacc_vld,
	input wire slice_arith_pkg::cplx35_t i_c35_a,
	input wire slice_arith_pkg::cplx18_t i_c35_b,
	output slice_arith_pkg::cplx_res_t o_c35_p,
	input wire slice_arith_pkg::rot_req_t i_rot,
	output logic [17:0] o_rot_q,
	output logic [17:0] o_rot1_q,
	output logic o_rot1_vld
);
	typedef struct packed {
		logic [5:0] mul_v;
		logic [1:0] ser_step;
		logic ser_busy;
		logic signed [69:0] ser_acc;
		logic ser_vld;
		logic signed [34:0] ser_a;
		logic signed [34:0] ser_b;
		logic signed [16:0] mul_mid;
		logic signed [17:0] a_hi_d1, a_hi_d2, a_hi_d3;
		logic signed [17:0] a_lo_d1, a_lo_d2;
		logic signed [17:0] b_hi_d1, b_hi_d2, b_hi_d3, b_lo_d1;
		slice_arith_pkg::multiply_accumulate_state_t multiply_accumulate_st;
		logic multiply_accumulate_vld;
		logic xmacc_vld;
		logic xmacc_first;
		logic rot1_phase;
		logic rot1_vld;
		logic [17:0] rot1_q;
		logic [17:0] rot_q;
		logic signed [47:0] rot1_p;
		slice_arith_pkg::cplx_res_t c18_p, multiply_accumulate_p, xmacc_p, c35_p;
		logic signed [47:0] x_re, x_im;
		logic signed [47:0] acc_rr;
		logic signed [47:0] acc_ii;
		logic signed [47:0] acc_ri;
		logic signed [47:0] acc_ir;
		logic multiply_accumulate_live;
		logic [17:0] rot_b;
		logic signed [47:0] rot_hold;
	} st_t;
	st_t r, nxt;

	// RULE19: low parts zero-extended so only top parts carry the sign
	function automatic logic signed [17:0] lo_part(input logic [34:0] v);
		lo_part = {1'b0, v[16:0]};
	endfunction
	function automatic logic signed [17:0] hi_part(input logic [34:0] v);
		hi_part = v[34:17];
	endfunction

	// 35x35 pipeline: four slices with cascade
	logic signed [47:0] p1, p2, p3, p4;
	logic [16:0] lo_aligned;
	arith_slice u_s1 (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_ce(i_ce),
		.i_a(lo_part(i_mul_in.a)), .i_b(lo_part(i_mul_in.b)), .i_cas('0),
		.i_operation_select(slice_arith_pkg::SEL_MUL), .i_subtract(1'b0), .o_p(p1)); // RULE18
	arith_slice u_s2 (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_ce(i_ce),
		.i_a(r.a_hi_d1), .i_b(r.b_lo_d1), .i_cas(p1),
		.i_operation_select(slice_arith_pkg::SEL_MUL_ADD_SHR), .i_subtract(1'b0), .o_p(p2)); // RULE18
	// slice three adds its product to the unshifted cascade of slice two
	arith_slice u_s3 (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_ce(i_ce),
		.i_a(r.a_lo_d2), .i_b(r.b_hi_d2), .i_cas(p2),
		.i_operation_select(slice_arith_pkg::SEL_MULTIPLY_ACCUMULATE), .i_subtract(1'b0), .o_p(p3)); // RULE18
	arith_slice u_s4 (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_ce(i_ce),
		.i_a(r.a_hi_d3), .i_b(r.b_hi_d3), .i_cas(p3),
		.i_operation_select(slice_arith_pkg::SEL_MUL_ADD_SHR), .i_subtract(1'b0), .o_p(p4)); // RULE18
	align_delay #(.W(slice_arith_pkg::PART_LO_W), .D(slice_arith_pkg::LO_ALIGN_DLY)) u_lo_dly (
		.i_mclk(i_mclk), .i_rstn(i_rstn), .i_ce(i_ce), .i_d(p1[16:0]), .o_q(lo_aligned)); // RULE4

	logic signed [47:0] rot_sh;
	logic signed [47:0] s1p, cas_in;
	always_comb begin
		nxt = r;
		// RULE3: operand parts held back to meet the cascade
		nxt.a_hi_d1 = hi_part(i_mul_in.a);
		nxt.b_lo_d1 = lo_part(i_mul_in.b);
		nxt.a_lo_d1 = lo_part(i_mul_in.a);
		nxt.a_lo_d2 = r.a_lo_d1;
		nxt.b_hi_d1 = hi_part(i_mul_in.b);
		nxt.b_hi_d2 = r.b_hi_d1;
		nxt.b_hi_d3 = r.b_hi_d2;
		nxt.a_hi_d2 = r.a_hi_d1;
		nxt.a_hi_d3 = r.a_hi_d2;
		nxt.mul_mid = p3[16:0];
		nxt.mul_v = {r.mul_v[4:0], i_mul_vld}; // RULE1

		// RULE2: serial form, one partial product per step
		if (i_ser_start && !r.ser_busy) begin
			nxt.ser_busy = 1'b1;
			nxt.ser_step = '0;
			nxt.ser_a = i_ser_in.a;
			nxt.ser_b = i_ser_in.b;
			nxt.ser_acc = 70'(lo_part(i_ser_in.a) * lo_part(i_ser_in.b));
			nxt.ser_vld = 1'b0;
		end else if (r.ser_busy) begin
			nxt.ser_step = r.ser_step + 2'h1;
			unique case (r.ser_step)
				2'h0: nxt.ser_acc = r.ser_acc + (70'(lo_part(r.ser_a) * hi_part(r.ser_b)) <<< 17);
				2'h1: nxt.ser_acc = r.ser_acc + (70'(hi_part(r.ser_a) * lo_part(r.ser_b)) <<< 17);
				2'h2: nxt.ser_acc = r.ser_acc + (70'(hi_part(r.ser_a) * hi_part(r.ser_b)) <<< 34);
				2'h3: nxt.ser_acc = r.ser_acc;
			endcase
			nxt.ser_busy = (r.ser_step != 2'h2);
			nxt.ser_vld = (r.ser_step == 2'h2);
		end else begin
			nxt.ser_vld = 1'b0;
		end

		// RULE6 RULE7: same chain, final subtract for real, add for imaginary
		nxt.c18_p.re = 48'(i_c18_a.re * i_c18_b.re) - 48'(i_c18_a.im * i_c18_b.im);
		nxt.c18_p.im = 48'(i_c18_a.re * i_c18_b.im) + 48'(i_c18_a.im * i_c18_b.re);

		// RULE11: wide operand split in two parts, partial products recombined
		nxt.c35_p.re = ((48'(hi_part(i_c35_a.re) * i_c35_b.re) <<< 17) + 48'(lo_part(i_c35_a.re) * i_c35_b.re))
			- ((48'(hi_part(i_c35_a.im) * i_c35_b.im) <<< 17) + 48'(lo_part(i_c35_a.im) * i_c35_b.im));
		nxt.c35_p.im = ((48'(hi_part(i_c35_a.re) * i_c35_b.im) <<< 17) + 48'(lo_part(i_c35_a.re) * i_c35_b.im))
			+ ((48'(hi_part(i_c35_a.im) * i_c35_b.re) <<< 17) + 48'(lo_part(i_c35_a.im) * i_c35_b.re));

		// RULE10: extra slice folds each product into its own running sum
		nxt.xmacc_vld = 1'b0;
		if (i_multiply_accumulate_vld) begin
			nxt.x_re = (r.xmacc_first ? 48'h0 : r.x_re) + nxt.c18_p.re;
			nxt.x_im = (r.xmacc_first ? 48'h0 : r.x_im) + nxt.c18_p.im;
			nxt.xmacc_first = i_multiply_accumulate_last;
			if (i_multiply_accumulate_last) begin
				nxt.xmacc_p.re = nxt.x_re;
				nxt.xmacc_p.im = nxt.x_im;
				nxt.xmacc_vld = 1'b1;
			end
		end

		// RULE8 RULE9: four cross products summed apart, combined in the stall cycle
		nxt.multiply_accumulate_vld = 1'b0;
		unique case (r.multiply_accumulate_st)
			slice_arith_pkg::MULTIPLY_ACCUMULATE_RUN: begin
				if (i_multiply_accumulate_vld) begin
					nxt.acc_rr = (r.multiply_accumulate_live ? r.acc_rr : 48'h0) + 48'(i_c18_a.re * i_c18_b.re); // RULE8
					nxt.acc_ii = (r.multiply_accumulate_live ? r.acc_ii : 48'h0) + 48'(i_c18_a.im * i_c18_b.im); // RULE8
					nxt.acc_ri = (r.multiply_accumulate_live ? r.acc_ri : 48'h0) + 48'(i_c18_a.re * i_c18_b.im); // RULE8
					nxt.acc_ir = (r.multiply_accumulate_live ? r.acc_ir : 48'h0) + 48'(i_c18_a.im * i_c18_b.re); // RULE8
					nxt.multiply_accumulate_live = !i_multiply_accumulate_last;
				end
				if (i_multiply_accumulate_vld && i_multiply_accumulate_last) begin
					nxt.multiply_accumulate_st = slice_arith_pkg::MULTIPLY_ACCUMULATE_DUMP;
				end
			end
			slice_arith_pkg::MULTIPLY_ACCUMULATE_DUMP: begin
				// no pair is taken here: the adders are busy combining
				nxt.multiply_accumulate_p.re = r.acc_rr - r.acc_ii; // RULE9
				nxt.multiply_accumulate_p.im = r.acc_ri + r.acc_ir; // RULE9
				nxt.multiply_accumulate_vld = 1'b1;
				nxt.multiply_accumulate_st = slice_arith_pkg::MULTIPLY_ACCUMULATE_RUN;
			end
		endcase

		// RULE12 RULE13 RULE14 RULE15: two-slice rotate
		s1p = 48'({1'b0, i_rot.data[17:1]}) <<< i_rot.amount; // RULE13
		rot_sh = 48'({30'h0, i_rot.data});
		nxt.rot1_p = s1p;
		nxt.rot_b = 18'(rot_sh <<< i_rot.amount); // RULE15
		cas_in = r.rot1_p >>> slice_arith_pkg::SHR_AMT; // RULE14
		// low n bits of the shifted operand are zero, so the add never carries
		nxt.rot_q = 18'(48'(r.rot_b) + cas_in); // RULE15 RULE16

		// RULE17: single-slice shifter alternates multiply / accumulate
		nxt.rot1_phase = ~r.rot1_phase;
		nxt.rot1_vld = r.rot1_phase;
		if (!r.rot1_phase) begin
			nxt.rot_hold = s1p;
		end else begin
			// operand must stand for both cycles of the pair
			nxt.rot1_q = 18'((r.rot_hold >>> slice_arith_pkg::SHR_AMT) + (rot_sh <<< i_rot.amount));
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			r <= '0;
			r.xmacc_first <= 1'b1;
		end else if (i_ce) begin
			r <= nxt;
		end
	end

	logic signed [69:0] mul_p_r;
	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			mul_p_r <= '0;
		end else if (i_ce) begin
			mul_p_r <= {p4[35:0], r.mul_mid, lo_aligned}; // RULE4
		end
	end

	assign o_unused_pad = '0;
	assign o_mul_p = mul_p_r;
	assign o_mul_vld = r.mul_v[5];
	assign o_ser_busy = r.ser_busy;
	assign o_ser_p = r.ser_acc;
	assign o_ser_vld = r.ser_vld;
	assign o_c18_p = r.c18_p;
	assign o_multiply_accumulate_stall = (r.multiply_accumulate_st == slice_arith_pkg::MULTIPLY_ACCUMULATE_DUMP); // RULE20
	assign o_multiply_accumulate_p = r.multiply_accumulate_p;
	assign o_multiply_accumulate_vld = r.multiply_accumulate_vld;
	assign o_xmacc_p = r.xmacc_p;
	assign o_xmacc_vld = r.xmacc_vld;
	assign o_c35_p = r.c35_p;
	assign o_rot_q = r.rot_q;
	assign o_rot1_q = r.rot1_q;
	assign o_rot1_vld = r.rot1_vld;

	AST_SER_FOUR: assert property (@(posedge i_mclk) disable iff (!i_rstn) // RULE2
		(i_ce && i_ser_start && !r.ser_busy) ##1 i_ce [*3] |=> o_ser_vld)
		else $error("serial product not ready after four cycles");
	AST_STALL_ONE: assert property (@(posedge i_mclk) disable iff (!i_rstn) // RULE9
		(i_ce && i_multiply_accumulate_vld && i_multiply_accumulate_last && r.multiply_accumulate_st == slice_arith_pkg::MULTIPLY_ACCUMULATE_RUN) |=> o_multiply_accumulate_stall)
		else $error("no stall after last accumulation");
	AST_C18_RE: assert property (@(posedge i_mclk) disable iff (!i_rstn) // RULE6
		i_ce |=> o_c18_p.re == $past(48'(i_c18_a.re * i_c18_b.re) - 48'(i_c18_a.im * i_c18_b.im)))
		else $error("complex real part wrong");
	AST_ROT1_ALT: assert property (@(posedge i_mclk) disable iff (!i_rstn) // RULE17
		(i_ce && o_rot1_vld) |=> !o_rot1_vld)
		else $error("single-slice shifter valid on two cycles in a row");
	AST_MUL_VLD: assert property (@(posedge i_mclk) disable iff (!i_rstn) // RULE1
		(i_ce && i_mul_vld) ##1 i_ce [*5] |=> o_mul_vld)
		else $error("product valid lost");
	AST_XMACC: assert property (@(posedge i_mclk) disable iff (!i_rstn) // RULE10
		(i_ce && i_multiply_accumulate_vld && i_multiply_accumulate_last) |=> o_xmacc_vld)
		else $error("extended accumulate result missing");
	AST_MULTIPLY_ACCUMULATE_ONE: assert property (@(posedge i_mclk) disable iff (!i_rstn) // RULE9
		(i_ce && o_multiply_accumulate_stall) |=> !o_multiply_accumulate_stall && o_multiply_accumulate_vld)
		else $error("stall not one cycle");
	AST_SER_BUSY: assert property (@(posedge i_mclk) disable iff (!i_rstn) // RULE2
		o_ser_vld |-> !o_ser_busy)
		else $error("serial busy with result");
	// accumulate end in two steps: last pair taken, then one stall and the report
	sequence seq_last_pair;
		i_ce && i_multiply_accumulate_vld && i_multiply_accumulate_last && r.multiply_accumulate_st == slice_arith_pkg::MULTIPLY_ACCUMULATE_RUN;
	endsequence
	sequence seq_stall_report;
		(o_multiply_accumulate_stall && i_ce) ##1 (o_multiply_accumulate_vld && !o_multiply_accumulate_stall);
	endsequence
	AST_MULTIPLY_ACCUMULATE_SEQ: assert property (@(posedge i_mclk) disable iff (!i_rstn) // RULE9
		seq_last_pair |=> seq_stall_report)
		else $error("accumulate end did not stall once and report");
	AST_C18_IM: assert property (@(posedge i_mclk) disable iff (!i_rstn) // RULE7
		i_ce |=> o_c18_p.im == $past(48'(i_c18_a.re * i_c18_b.im) + 48'(i_c18_a.im * i_c18_b.re)))
		else $error("complex imaginary part wrong");
	AST_ROT_WRAP: assert property (@(posedge i_mclk) disable iff (!i_rstn) // RULE12
		(i_ce ##1 i_ce) |=> o_rot_q == 18'((36'({$past(i_rot.data, 2), $past(i_rot.data, 2)})
		<< $past(i_rot.amount, 2)) >> 18))
		else $error("rotation result wrong");
endmodule // pipelined_slice_arith

// ---- common/slice_arith_pkg.sv ----
package slice_arith_pkg;
	localparam int OP_W = 7;
	localparam logic [6:0] SEL_MUL = 7'h05;
	localparam logic [6:0] SEL_MULTIPLY_ACCUMULATE = 7'h25;
	localparam logic [6:0] SEL_MUL_ADD_SHR = 7'h65;
	localparam logic [6:0] SEL_HOLD = 7'h00;
	localparam int PART_LO_W = 17;
	localparam int SHR_AMT = 17;
	localparam int SLICE_P_W = 48;
	localparam int WIDE_W = 35;
	localparam int NARROW_W = 18;
	localparam int SHIFT_W = 5;
	localparam int LO_ALIGN_DLY = 3;
	localparam int SERIAL_STEPS = 4;
	localparam int PROD_W = 70;
	localparam int CPLX_W = 48;
	localparam logic [4:0] SHIFT_MAX = 5'h11;

	typedef struct packed {
		logic signed [WIDE_W-1:0] a;
		logic signed [WIDE_W-1:0] b;
	} wide_pair_t;

	typedef struct packed {
		logic signed [NARROW_W-1:0] re;
		logic signed [NARROW_W-1:0] im;
	} cplx18_t;

	typedef struct packed {
		logic signed [WIDE_W-1:0] re;
		logic signed [WIDE_W-1:0] im;
	} cplx35_t;

	typedef struct packed {
		logic signed [CPLX_W-1:0] re;
		logic signed [CPLX_W-1:0] im;
	} cplx_res_t;

	typedef struct packed {
		logic [NARROW_W-1:0] data;
		logic [SHIFT_W-1:0] amount;
	} rot_req_t;

	typedef enum logic [1:0] {
		MULTIPLY_ACCUMULATE_RUN,
		MULTIPLY_ACCUMULATE_DUMP
	} multiply_accumulate_state_t;
endpackage

// ---- verilog/arith_slice.sv ----
`timescale 1ns/100ps
// one multiply-add slice: multiplier register, then accumulator register
module arith_slice (
	input wire logic i_mclk,
	input wire logic i_rstn,
	input wire logic i_ce,
	input wire logic signed [17:0] i_a,
	input wire logic signed [17:0] i_b,
	input wire logic signed [47:0] i_cas,
	input wire logic [6:0] i_operation_select,
	input wire logic i_subtract,
	output logic signed [47:0] o_p
);
	typedef struct packed {
		logic signed [35:0] m;
		logic [6:0] sel;
		logic sub;
		logic signed [47:0] p;
	} st_t;
	st_t r, nxt;
	logic signed [47:0] z;
	logic signed [47:0] mx;

	always_comb begin
		nxt = r;
		nxt.m = i_a * i_b;
		nxt.sel = i_operation_select;
		nxt.sub = i_subtract;
		mx = 48'(r.m);
		// cascade is the previous slice's output register, so no extra stage here
		unique case (r.sel)
			slice_arith_pkg::SEL_MULTIPLY_ACCUMULATE: z = i_cas;
			slice_arith_pkg::SEL_MUL_ADD_SHR: z = i_cas >>> slice_arith_pkg::SHR_AMT;
			default: z = '0;
		endcase
		if (r.sel == slice_arith_pkg::SEL_HOLD) begin
			nxt.p = r.p;
		end else if (r.sub) begin
			nxt.p = z - mx;
		end else begin
			nxt.p = z + mx;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			r <= '0;
		end else if (i_ce) begin
			r <= nxt;
		end
	end
	assign o_p = r.p;
endmodule // arith_slice

// ---- verilog/align_delay.sv ----
`timescale 1ns/100ps
// shift chain then a final flip-flop; depth 1 collapses to one flip-flop
module align_delay #(
	parameter int W = 17,
	parameter int D = 3
) (
	input wire logic i_mclk,
	input wire logic i_rstn,
	input wire logic i_ce,
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);
	logic [D-1:0][W-1:0] sr_r;
	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			sr_r <= '0;
		end else if (i_ce) begin
			sr_r[0] <= i_d; // RULE5
			for (int k = 1; k < D; k++) begin
				sr_r[k] <= sr_r[k-1];
			end
		end
	end
	assign o_q = sr_r[D-1];
endmodule // align_delay

// ---- bench/fabric_source.sv ----
`timescale 1ns/100ps
// operand supplier for the complex accumulate, as the surrounding fabric would be
module fabric_source (
	input wire logic i_mclk,
	input wire logic i_rstn,
	input wire logic i_stall,
	input wire logic i_go,
	input wire logic [3:0] i_n,
	input wire slice_arith_pkg::cplx18_t i_a,
	input wire slice_arith_pkg::cplx18_t i_b,
	output slice_arith_pkg::cplx18_t o_a,
	output slice_arith_pkg::cplx18_t o_b,
	output logic o_vld,
	output logic o_last,
	output slice_arith_pkg::cplx_res_t o_exp
);
	logic [3:0] left = 4'h0;
	slice_arith_pkg::cplx_res_t acc = '0;
	logic signed [47:0] ar, ai, br, bi;
	initial begin
		o_a = '0;
		o_b = '0;
		o_vld = 1'b0;
		o_last = 1'b0;
	end
	assign ar = o_a.re;
	assign ai = o_a.im;
	assign br = o_b.re;
	assign bi = o_b.im;
	assign o_exp.re = acc.re + ar * br - ai * bi;
	assign o_exp.im = acc.im + ar * bi + ai * br;
	// non-blocking so the bench samples the sum before this edge's pair lands
	always @(posedge i_mclk) begin
		if (!i_rstn || (o_vld && o_last))
			acc <= '0;
		else if (o_vld)
			acc <= o_exp;
		#2;
		if (i_go && left == 4'h0)
			left = i_n;
		if (!i_rstn || i_stall || left == 4'h0) begin
			o_vld = 1'b0;
			o_last = 1'b0;
		end else begin
			o_vld = 1'b1;
			o_last = (left == 4'h1);
			o_a = i_a;
			o_b = i_b;
			left = left - 4'h1;
		end
	end
endmodule // fabric_source

// ---- bench/testbench.sv ----
`timescale 1ns/100ps
module testbench;
	logic i_mclk, i_rstn, i_ce, mul_vld_in, ser_start, go;
	logic [3:0] n;
	slice_arith_pkg::wide_pair_t mul_in, ser_in;
	slice_arith_pkg::cplx18_t sa, sb, c18_a, c18_b, c35_b;
	slice_arith_pkg::cplx35_t c35_a;
	slice_arith_pkg::rot_req_t rot;
	logic signed [69:0] mul_p, ser_p;
	slice_arith_pkg::cplx_res_t c18_p, multiply_accumulate_p, xmacc_p, c35_p, exp_sum;
	logic mul_vld, ser_busy, ser_vld, multiply_accumulate_vld, xmacc_vld, stall, m_vld, m_last;
	logic [17:0] rot_q, rot1_q;
	logic [15:0] lfsr = 16'h8590;
	logic [69:0] v;
	logic [35:0] t;
	int fails = 0;
	int tests_run = 0;
	int cyc = 0;
	logic signed [69:0] q_mul[$], q_ser[$];
	slice_arith_pkg::cplx_res_t q_c18[$], q_c35[$], q_multiply_accumulate[$], q_xm[$];

	pipelined_slice_arith i_pipelined_slice_arith (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_ce(i_ce),
		.i_mul_in(mul_in), .i_mul_vld(mul_vld_in), .o_unused_pad(), .o_mul_p(mul_p), .o_mul_vld(mul_vld),
		.i_ser_in(ser_in), .i_ser_start(ser_start), .o_ser_busy(ser_busy), .o_ser_p(ser_p), .o_ser_vld(ser_vld),
		.i_c18_a(c18_a), .i_c18_b(c18_b), .o_c18_p(c18_p), .i_multiply_accumulate_vld(m_vld), .i_multiply_accumulate_last(m_last),
		.o_multiply_accumulate_stall(stall), .o_multiply_accumulate_p(multiply_accumulate_p), .o_multiply_accumulate_vld(multiply_accumulate_vld), .o_xmacc_p(xmacc_p),
		.o_xmacc_vld(xmacc_vld), .i_c35_a(c35_a), .i_c35_b(c35_b), .o_c35_p(c35_p), .i_rot(rot),
		.o_rot_q(rot_q), .o_rot1_q(rot1_q), .o_rot1_vld());

	fabric_source i_fabric_source (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_stall(stall), .i_go(go), .i_n(n),
		.i_a(sa), .i_b(sb), .o_a(c18_a), .o_b(c18_b), .o_vld(m_vld), .o_last(m_last), .o_exp(exp_sum));

	initial begin
		i_mclk = 1'b0;
		forever #50 i_mclk = ~i_mclk;
	end

	task automatic rnd(output logic [69:0] r);
		for (int k = 0; k < 5; k++) begin
			lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
			r = {r[53:0], lfsr};
		end
	endtask

	function automatic slice_arith_pkg::cplx_res_t cmul(input logic signed [47:0] ar, ai, br, bi);
		cmul.re = ar * br - ai * bi;
		cmul.im = ar * bi + ai * br;
	endfunction

	task automatic check(input logic [95:0] got, input logic [95:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// expectations noted at the edge that takes the operands
	always @(posedge i_mclk) if (i_rstn && i_ce) begin
		if (mul_vld_in)
			q_mul.push_back(70'(mul_in.a) * 70'(mul_in.b));
		q_c18.push_back(cmul(c18_a.re, c18_a.im, c18_b.re, c18_b.im));
		q_c35.push_back(cmul(c35_a.re, c35_a.im, c35_b.re, c35_b.im));
		if (m_vld && m_last) begin
			q_multiply_accumulate.push_back(exp_sum);
			q_xm.push_back(exp_sum);
		end
	end

	always @(negedge i_mclk) if (i_rstn) begin
		if (mul_vld) check(mul_p, q_mul.pop_front(), "wide product");
		if (ser_vld) check(ser_p, q_ser.pop_front(), "serial product");
		if (q_c18.size() > 0) check(c18_p, q_c18.pop_front(), "complex 18x18");
		if (q_c35.size() > 0) check(c35_p, q_c35.pop_front(), "complex 35x18");
		if (multiply_accumulate_vld) check(multiply_accumulate_p, q_multiply_accumulate.pop_front(), "accumulate");
		if (xmacc_vld) check(xmacc_p, q_xm.pop_front(), "extended accumulate");
	end

	always @(posedge i_mclk) begin
		cyc++;
		if (cyc > 3000) begin
			fails++;
			$display("ERROR %0t run did not complete", $time);
			finish_test();
		end
	end

	initial begin
		{i_rstn, mul_vld_in, ser_start, go} = 4'h0;
		i_ce = 1'b1;
		n = 4'h3;
		{mul_in, ser_in, c35_a, c35_b, rot, sa, sb} = '0;
		repeat (2) @(posedge i_mclk);
		#1 i_rstn = 1'b1;
		// back-to-back streams; accumulations of three then of one
		for (int k = 0; k < 14; k++) begin
			rnd(v);
			mul_in = v;
			if (k == 0) mul_in = {35'h400000000, 35'h400000000};
			if (k == 1) mul_in = {35'h3FFFFFFFF, 35'h400000000};
			mul_vld_in = (k != 6);
			rnd(v);
			c35_a = v;
			sa = v[35:0];
			rnd(v);
			c35_b = v[35:0];
			sb = v[69:34];
			go = (k < 11);
			n = (k < 6) ? 4'h3 : 4'h1;
			@(posedge i_mclk);
			#1;
		end
		{mul_vld_in, go} = 2'b00;
		for (int k = 0; k < 2; k++) begin
			rnd(v);
			ser_in = (k == 0) ? {35'h400000000, 35'h3FFFFFFFF} : v;
			q_ser.push_back(70'(ser_in.a) * 70'(ser_in.b));
			ser_start = 1'b1;
			@(posedge i_mclk);
			#1 ser_start = 1'b0;
			// a start while busy must be ignored
			@(posedge i_mclk);
			#1 ser_start = 1'b1;
			ser_in = ~ser_in;
			@(posedge i_mclk);
			#1 ser_start = 1'b0;
			for (int w = 0; w < 12 && q_ser.size() > 0; w++) @(posedge i_mclk);
			#1;
		end
		for (int a = 0; a < 18; a++) begin
			rnd(v);
			rot.data = v[17:0];
			rot.amount = a[4:0];
			repeat (4) @(posedge i_mclk);
			t = {rot.data, rot.data} << a;
			#1 check(rot_q, t[35:18], "rotation");
			check(rot1_q, t[35:18], "single-slice rotation");
		end
		repeat (10) @(posedge i_mclk);
		if (q_mul.size() + q_ser.size() + q_multiply_accumulate.size() + q_xm.size() != 0) begin
			fails++;
			$display("ERROR %0t results missing", $time);
		end
		finish_test();
	end
endmodule // testbench
